// File: hw/scsre_store_exec.sv
`timescale 1ns/1ps
// Notes on behaviour
// - store to gpr copies status, global base or vector base in one cycle.
// - modulo, repeat end, repeat start to gpr exist only with dsp enabled.
// - status push takes two cycles, decrements by four, writes longword.
// - global and vector base pushes take two cycles, longword after decrement.
// - dsp-only control pushes take two cycles; repeat start pushes repeat start.
// - every push writes back address minus four; an aligned one also writes there in the same cycle.
// - mac high, mac low, procedure return go to gpr in one cycle.
// - dsp registers go to gpr in one cycle, dsp variant only.
// - mac and procedure return pushes take one cycle, longword after decrement.
// - dsp register pushes; accumulator opcode collision resolved before decode.
// - interrupts blocked until the following instruction has executed.
// - interrupt block never hides an address error on a push.
// - narrow variant sign-extends mac high bit 9 into bits 31 to 10.
// - later variants store all 32 mac high bits unchanged.
// - completion advances program counter by two.
module scsre_store_exec
    import scsre_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic issue_valid,
    output logic issue_ready,
    input wire logic [15:0] opcode,
    input wire logic [31:0] pc,
    input wire logic dsp_en,
    input wire logic mac_narrow,
    input wire logic [31:0] status_reg,
    input wire logic [31:0] global_base_reg,
    input wire logic [31:0] vector_base_reg,
    input wire logic [31:0] modulo_addr_reg,
    input wire logic [31:0] repeat_end_reg,
    input wire logic [31:0] repeat_start_reg,
    input wire logic [31:0] mac_high,
    input wire logic [31:0] mac_low,
    input wire logic [31:0] procedure_return_reg,
    input wire logic [31:0] dsp_status_reg,
    input wire logic [31:0] dsp_accum_zero,
    input wire logic [31:0] dsp_x0,
    input wire logic [31:0] dsp_x1,
    input wire logic [31:0] dsp_y0,
    input wire logic [31:0] dsp_y1,
    output logic [3:0] gpr_rd_idx,
    input wire logic [31:0] gpr_rd_data,
    output logic gpr_we,
    output logic [3:0] gpr_wr_idx,
    output logic [31:0] gpr_wr_data,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_data,
    output logic addr_error,
    output logic unknown_op,
    output logic done,
    output logic [31:0] pc_next,
    input wire logic other_retire,
    output logic int_block
);

    // ****************************************
    // decode
    // ****************************************
    scsre_dec_if dif ();
    scsre_state_t state;
    scsre_state_t next_state;

    // opcode and variant straight onto the carrier
    assign dif.opcode = opcode;
    assign dif.dsp_en = dsp_en;

    // decoder is pure logic; the carrier keeps its fields together
    scsre_decoder u_dec (
        .dif(dif)
    );

    // mac high as stored; the narrow core only keeps ten live bits
    // the narrow result keeps its sign for register and memory stores alike
    function automatic logic [31:0] mac_high_view(input logic [31:0] v, input logic narrow);
        if (narrow) begin
            mac_high_view = {{22{v[MAC_HIGH_SIGN_BIT]}}, v[MAC_HIGH_SIGN_BIT:0]};
        end else begin
            mac_high_view = v;
        end
    endfunction

    // ****************************************
    // source select and address
    // ****************************************
    logic [31:0] src_val;

    // sources are only read here, nothing writes them back; no flag output exists
    always_comb begin
        case (dif.src)
            SCSRE_SRC_STATUS: src_val = status_reg;
            SCSRE_SRC_GBASE: src_val = global_base_reg;
            SCSRE_SRC_VBASE: src_val = vector_base_reg;
            SCSRE_SRC_MOD: src_val = modulo_addr_reg;
            SCSRE_SRC_REND: src_val = repeat_end_reg;
            SCSRE_SRC_RSTART: src_val = repeat_start_reg;
            SCSRE_SRC_MAC_HIGH: src_val = mac_high_view(mac_high, mac_narrow);
            SCSRE_SRC_MAC_LOW: src_val = mac_low;
            SCSRE_SRC_PR: src_val = procedure_return_reg;
            SCSRE_SRC_DSR: src_val = dsp_status_reg;
            SCSRE_SRC_A0: src_val = dsp_accum_zero;
            SCSRE_SRC_X0: src_val = dsp_x0;
            SCSRE_SRC_X1: src_val = dsp_x1;
            SCSRE_SRC_Y0: src_val = dsp_y0;
            SCSRE_SRC_Y1: src_val = dsp_y1;
            default: src_val = WORD_RESET;
        endcase
    end

    // take qualifiers; an unknown word is taken but does no work
    wire is_idle = (state == SCSRE_ST_IDLE);
    wire is_hold = (state == SCSRE_ST_HOLD);
    wire take = issue_valid & is_idle;
    wire good = take & dif.hit;
    wire finish_now = good & ~dif.two_cyc;
    wire next_done = finish_now | is_hold;

    // ****************************************
    // push address and alignment
    // ****************************************
    // only longword alignment is judged; no other illegal range is decoded here
    wire [31:0] push_addr = gpr_rd_data - PUSH_STEP;
    wire misaligned = (push_addr[1:0] != 2'b00);
    wire push_take = good & dif.push;
    wire mem_go = push_take & ~misaligned;
    wire err_go = push_take & misaligned;
    // a push writes back the reduced address, a plain store its source
    wire [31:0] gpr_value = dif.push ? push_addr : src_val;

    // ready is combinational so the pipeline sees the bubble at once
    assign issue_ready = is_idle;
    assign gpr_rd_idx = dif.rn;

    // ****************************************
    // sequencing: control pushes hold one extra cycle
    // ****************************************
    // one-hot pair; hold never lasts more than one cycle
    always_comb begin
        case (state)
            SCSRE_ST_IDLE: next_state = (good & dif.two_cyc) ? SCSRE_ST_HOLD : SCSRE_ST_IDLE;
            SCSRE_ST_HOLD: next_state = SCSRE_ST_IDLE;
            default: next_state = SCSRE_ST_IDLE;
        endcase
    end

    // reset lands in idle, so an offer may come at the first edge after
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SCSRE_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // register and memory writes
    // ****************************************
    // index and data hold until the next decoded word
    always_ff @(posedge clk) begin
        if (rst) begin
            gpr_we <= 1'b0;
            gpr_wr_idx <= IDX_RESET;
            gpr_wr_data <= WORD_RESET;
        end else begin
            gpr_we <= good;
            if (good) begin
                gpr_wr_idx <= dif.rn;
                gpr_wr_data <= gpr_value;
            end
        end
    end

    // a misaligned push still flags its error, the write itself is dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_we <= 1'b0;
            mem_addr <= WORD_RESET;
            mem_data <= WORD_RESET;
            addr_error <= 1'b0;
        end else begin
            mem_we <= mem_go;
            addr_error <= err_go;
            if (push_take) begin
                mem_addr <= push_addr;
                mem_data <= src_val;
            end
        end
    end

    // ****************************************
    // completion, pc and interrupt block
    // ****************************************
    // pc_next only moves on a decoded word; refused words leave it alone
    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
            unknown_op <= 1'b0;
            pc_next <= WORD_RESET;
        end else begin
            done <= next_done;
            unknown_op <= take & ~dif.hit;
            if (good) begin
                pc_next <= pc + PC_STEP;
            end
        end
    end

    // set on our own completion wins over the retire that would clear it
    // a retire in the cycle of our own completion is therefore ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            int_block <= 1'b0;
        end else begin
            int_block <= next_done | (int_block & ~other_retire);
        end
    end

endmodule

// File: hw/scsre_pkg.sv
package scsre_pkg;

    // ****************************************
    // opcode fields
    // ****************************************
    localparam logic [3:0] OP_HI_TO_GPR = 4'h0;
    localparam logic [3:0] OP_HI_PUSH = 4'h4;
    localparam int RN_MSB = 11;
    localparam int RN_LSB = 8;

    // low bytes, register-destination forms
    localparam logic [7:0] LO_GPR_STATUS = 8'h02;
    localparam logic [7:0] LO_GPR_GBASE = 8'h12;
    localparam logic [7:0] LO_GPR_VBASE = 8'h22;
    localparam logic [7:0] LO_GPR_MOD = 8'h52;
    localparam logic [7:0] LO_GPR_RSTART = 8'h62;
    localparam logic [7:0] LO_GPR_REND = 8'h72;
    localparam logic [7:0] LO_GPR_MAC_HIGH = 8'h0a;
    localparam logic [7:0] LO_GPR_MAC_LOW = 8'h1a;
    localparam logic [7:0] LO_GPR_PR = 8'h2a;
    localparam logic [7:0] LO_GPR_DSR = 8'h6a;
    localparam logic [7:0] LO_GPR_A0 = 8'h7a;
    localparam logic [7:0] LO_GPR_X0 = 8'h8a;
    localparam logic [7:0] LO_GPR_X1 = 8'h9a;
    localparam logic [7:0] LO_GPR_Y0 = 8'haa;
    localparam logic [7:0] LO_GPR_Y1 = 8'hba;

    // low bytes, pre-decrement push forms
    localparam logic [7:0] LO_PSH_STATUS = 8'h03;
    localparam logic [7:0] LO_PSH_GBASE = 8'h13;
    localparam logic [7:0] LO_PSH_VBASE = 8'h23;
    localparam logic [7:0] LO_PSH_MOD = 8'h53;
    localparam logic [7:0] LO_PSH_RSTART = 8'h63;
    localparam logic [7:0] LO_PSH_REND = 8'h73;
    localparam logic [7:0] LO_PSH_MAC_HIGH = 8'h02;
    localparam logic [7:0] LO_PSH_MAC_LOW = 8'h12;
    localparam logic [7:0] LO_PSH_PR = 8'h22;
    localparam logic [7:0] LO_PSH_DSR = 8'h62;
    localparam logic [7:0] LO_PSH_A0 = 8'h72;
    localparam logic [7:0] LO_PSH_X0 = 8'h82;
    localparam logic [7:0] LO_PSH_X1 = 8'h92;
    localparam logic [7:0] LO_PSH_Y0 = 8'ha2;
    localparam logic [7:0] LO_PSH_Y1 = 8'hb2;

    // ****************************************
    // arithmetic and reset values
    // ****************************************
    localparam logic [31:0] PUSH_STEP = 32'h0000_0004;
    localparam logic [31:0] PC_STEP = 32'h0000_0002;
    localparam int MAC_HIGH_SIGN_BIT = 9;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [3:0] IDX_RESET = 4'h0;

    typedef enum logic [3:0] {
        SCSRE_SRC_STATUS = 4'h0,
        SCSRE_SRC_GBASE = 4'h1,
        SCSRE_SRC_VBASE = 4'h2,
        SCSRE_SRC_MOD = 4'h3,
        SCSRE_SRC_REND = 4'h4,
        SCSRE_SRC_RSTART = 4'h5,
        SCSRE_SRC_MAC_HIGH = 4'h6,
        SCSRE_SRC_MAC_LOW = 4'h7,
        SCSRE_SRC_PR = 4'h8,
        SCSRE_SRC_DSR = 4'h9,
        SCSRE_SRC_A0 = 4'ha,
        SCSRE_SRC_X0 = 4'hb,
        SCSRE_SRC_X1 = 4'hc,
        SCSRE_SRC_Y0 = 4'hd,
        SCSRE_SRC_Y1 = 4'he
    } scsre_src_t;

    typedef enum logic [1:0] {
        SCSRE_ST_IDLE = 2'b01,
        SCSRE_ST_HOLD = 2'b10
    } scsre_state_t;

endpackage

// File: hw/scsre_dec_if.sv
`timescale 1ns/1ps
interface scsre_dec_if;
    import scsre_pkg::*;
    logic [15:0] opcode;
    logic dsp_en;
    logic hit;
    logic push;
    logic two_cyc;
    scsre_src_t src;
    logic [3:0] rn;
    modport dec (input opcode, input dsp_en, output hit, output push, output two_cyc,
        output src, output rn);
    modport exe (output opcode, output dsp_en, input hit, input push, input two_cyc,
        input src, input rn);
endinterface

// File: hw/scsre_decoder.sv
`timescale 1ns/1ps
module scsre_decoder
    import scsre_pkg::*;
(
    scsre_dec_if.dec dif
);

    // ****************************************
    // opcode split
    // ****************************************
    wire [3:0] op_hi = dif.opcode[15:12];
    wire [7:0] op_lo = dif.opcode[7:0];
    logic known;
    logic dsp_only;
    logic ctrl_push;
    scsre_src_t src_sel;

    // table lookup; the dsp forms vanish when the variant lacks them
    always_comb begin
        known = 1'b1;
        dsp_only = 1'b0;
        ctrl_push = 1'b0;
        src_sel = SCSRE_SRC_STATUS;
        if (op_hi == OP_HI_TO_GPR) begin
            case (op_lo)
                LO_GPR_STATUS: src_sel = SCSRE_SRC_STATUS;
                LO_GPR_GBASE: src_sel = SCSRE_SRC_GBASE;
                LO_GPR_VBASE: src_sel = SCSRE_SRC_VBASE;
                LO_GPR_MOD: begin
                    src_sel = SCSRE_SRC_MOD;
                    dsp_only = 1'b1;
                end
                LO_GPR_REND: begin
                    src_sel = SCSRE_SRC_REND;
                    dsp_only = 1'b1;
                end
                LO_GPR_RSTART: begin
                    src_sel = SCSRE_SRC_RSTART;
                    dsp_only = 1'b1;
                end
                LO_GPR_MAC_HIGH: src_sel = SCSRE_SRC_MAC_HIGH;
                LO_GPR_MAC_LOW: src_sel = SCSRE_SRC_MAC_LOW;
                LO_GPR_PR: src_sel = SCSRE_SRC_PR;
                LO_GPR_DSR: begin
                    src_sel = SCSRE_SRC_DSR;
                    dsp_only = 1'b1;
                end
                LO_GPR_A0: begin
                    src_sel = SCSRE_SRC_A0;
                    dsp_only = 1'b1;
                end
                LO_GPR_X0: begin
                    src_sel = SCSRE_SRC_X0;
                    dsp_only = 1'b1;
                end
                LO_GPR_X1: begin
                    src_sel = SCSRE_SRC_X1;
                    dsp_only = 1'b1;
                end
                LO_GPR_Y0: begin
                    src_sel = SCSRE_SRC_Y0;
                    dsp_only = 1'b1;
                end
                LO_GPR_Y1: begin
                    src_sel = SCSRE_SRC_Y1;
                    dsp_only = 1'b1;
                end
                default: known = 1'b0;
            endcase
        end else if (op_hi == OP_HI_PUSH) begin
            case (op_lo)
                LO_PSH_STATUS: begin
                    src_sel = SCSRE_SRC_STATUS;
                    ctrl_push = 1'b1;
                end
                LO_PSH_GBASE: begin
                    src_sel = SCSRE_SRC_GBASE;
                    ctrl_push = 1'b1;
                end
                LO_PSH_VBASE: begin
                    src_sel = SCSRE_SRC_VBASE;
                    ctrl_push = 1'b1;
                end
                LO_PSH_MOD: begin
                    src_sel = SCSRE_SRC_MOD;
                    ctrl_push = 1'b1;
                    dsp_only = 1'b1;
                end
                LO_PSH_REND: begin
                    src_sel = SCSRE_SRC_REND;
                    ctrl_push = 1'b1;
                    dsp_only = 1'b1;
                end
                LO_PSH_RSTART: begin
                    src_sel = SCSRE_SRC_RSTART;
                    ctrl_push = 1'b1;
                    dsp_only = 1'b1;
                end
                LO_PSH_MAC_HIGH: src_sel = SCSRE_SRC_MAC_HIGH;
                LO_PSH_MAC_LOW: src_sel = SCSRE_SRC_MAC_LOW;
                LO_PSH_PR: src_sel = SCSRE_SRC_PR;
                // accumulator push decoded at 0x72; the printed code aliases dsp status
                LO_PSH_DSR: begin
                    src_sel = SCSRE_SRC_DSR;
                    dsp_only = 1'b1;
                end
                LO_PSH_A0: begin
                    src_sel = SCSRE_SRC_A0;
                    dsp_only = 1'b1;
                end
                LO_PSH_X0: begin
                    src_sel = SCSRE_SRC_X0;
                    dsp_only = 1'b1;
                end
                LO_PSH_X1: begin
                    src_sel = SCSRE_SRC_X1;
                    dsp_only = 1'b1;
                end
                LO_PSH_Y0: begin
                    src_sel = SCSRE_SRC_Y0;
                    dsp_only = 1'b1;
                end
                LO_PSH_Y1: begin
                    src_sel = SCSRE_SRC_Y1;
                    dsp_only = 1'b1;
                end
                default: known = 1'b0;
            endcase
        end else begin
            known = 1'b0;
        end
    end

    // results onto the carrier
    assign dif.hit = known & (~dsp_only | dif.dsp_en);
    assign dif.push = (op_hi == OP_HI_PUSH);
    assign dif.two_cyc = ctrl_push;
    assign dif.src = src_sel;
    assign dif.rn = dif.opcode[RN_MSB:RN_LSB];

endmodule

// File: verif/scsre_monitor.sv
`timescale 1ns/1ps
// ********************
// executor port checker
// ********************
module scsre_monitor
    import scsre_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire logic issue_ready,
    input wire logic [15:0] opcode,
    input wire logic [31:0] pc,
    input wire logic mac_narrow,
    input wire logic [31:0] mac_high,
    input wire logic [3:0] gpr_rd_idx,
    input wire logic [31:0] gpr_rd_data,
    input wire logic gpr_we,
    input wire logic [3:0] gpr_wr_idx,
    input wire logic [31:0] gpr_wr_data,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic addr_error,
    input wire logic done,
    input wire logic [31:0] pc_next,
    input wire logic other_retire,
    input wire logic int_block
);
    // take and opcode classes
    wire take = issue_valid && issue_ready;
    wire psh = take && opcode[15:12] == OP_HI_PUSH;
    wire ctl = psh && opcode[3:0] == 4'h3;
    wire nrw = take && mac_narrow && opcode == {OP_HI_TO_GPR, opcode[11:8], LO_GPR_MAC_HIGH};
    logic [31:0] pc_q;

    // done trails a control push by two cycles, so keep the taken pc
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_q <= '0;
        end else if (take) begin
            pc_q <= pc;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    pc_step_a: assert property (done |-> pc_next == pc_q + PC_STEP)
        else $error("pc_next not pc plus two");
    gpr_index_a: assert property (take |-> gpr_rd_idx == opcode[11:8]
        ##1 (!gpr_we || gpr_wr_idx == $past(opcode[11:8])))
        else $error("gpr index mismatch");
    push_addr_a: assert property (psh ##1 gpr_we |->
        gpr_wr_data == $past(gpr_rd_data) - PUSH_STEP && (!mem_we || mem_addr == gpr_wr_data))
        else $error("push address not reduced by four");
    addr_err_a: assert property (psh ##1 gpr_we |->
        addr_error == (gpr_wr_data[1:0] != 2'b00) && mem_we == !addr_error)
        else $error("address error and write disagree");
    ctl_two_a: assert property (ctl ##1 gpr_we |-> !issue_ready && !done ##1 done)
        else $error("control push not two cycles");
    one_cyc_a: assert property ((take && opcode[3:0] != 4'h3) ##1 gpr_we |-> done)
        else $error("one cycle form without done");
    int_set_a: assert property (done |-> int_block)
        else $error("int_block low on done");
    int_hold_a: assert property (int_block && !other_retire |=> int_block)
        else $error("int_block dropped early");
    mac_high_sext_a: assert property (nrw ##1 gpr_we |->
        gpr_wr_data == {{22{$past(mac_high[9])}}, $past(mac_high[9:0])})
        else $error("narrow mac_high not sign extended");
endmodule

bind scsre_store_exec scsre_monitor scsre_monitor_inst (.clk, .rst, .issue_valid,
    .issue_ready, .opcode, .pc, .mac_narrow, .mac_high, .gpr_rd_idx, .gpr_rd_data, .gpr_we,
    .gpr_wr_idx, .gpr_wr_data, .mem_we, .mem_addr, .addr_error, .done, .pc_next,
    .other_retire, .int_block);

// File: verif/scsre_core_model.sv
`timescale 1ns/1ps
// ********************
// general register file of the pipeline
// ********************
module scsre_core_model
(
    input wire logic clk,
    input wire logic [3:0] gpr_rd_idx,
    output logic [31:0] gpr_rd_data,
    input wire logic gpr_we,
    input wire logic [3:0] gpr_wr_idx,
    input wire logic [31:0] gpr_wr_data
);
    logic [31:0] gpr [16];

    // same-cycle read; the executor has no wait state on it
    assign gpr_rd_data = gpr[gpr_rd_idx];

    // writes land on the clock edge
    always @(posedge clk) begin
        if (gpr_we) begin
            gpr[gpr_wr_idx] <= gpr_wr_data;
        end
    end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
// ********************
// executor testbench
// ********************
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic issue_valid = 1'b0;
    logic dsp_en = 1'b1;
    logic mac_narrow = 1'b0;
    logic other_retire = 1'b0;
    logic [15:0] opcode = 16'h0000;
    logic [31:0] pc = 32'h0000_1000;
    logic [31:0] src [15];
    logic issue_ready, gpr_we, mem_we, addr_error, unknown_op, done, int_block;
    logic [3:0] gpr_rd_idx, gpr_wr_idx;
    logic [31:0] gpr_rd_data, gpr_wr_data, mem_addr, mem_data, pc_next;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    // low bytes in source order: status, gbase, vbase, mod, rend, rstart, mac_high..y1
    logic [7:0] lo_g [15] = '{8'h02, 8'h12, 8'h22, 8'h52, 8'h72, 8'h62, 8'h0a, 8'h1a,
        8'h2a, 8'h6a, 8'h7a, 8'h8a, 8'h9a, 8'haa, 8'hba};
    logic [7:0] lo_p [15] = '{8'h03, 8'h13, 8'h23, 8'h53, 8'h73, 8'h63, 8'h02, 8'h12,
        8'h22, 8'h62, 8'h72, 8'h82, 8'h92, 8'ha2, 8'hb2};

    scsre_store_exec scsre_store_exec_inst (
        .clk, .rst, .issue_valid, .issue_ready, .opcode, .pc, .dsp_en, .mac_narrow,
        .status_reg(src[0]), .global_base_reg(src[1]), .vector_base_reg(src[2]),
        .modulo_addr_reg(src[3]), .repeat_end_reg(src[4]), .repeat_start_reg(src[5]),
        .mac_high(src[6]), .mac_low(src[7]), .procedure_return_reg(src[8]),
        .dsp_status_reg(src[9]), .dsp_accum_zero(src[10]), .dsp_x0(src[11]),
        .dsp_x1(src[12]), .dsp_y0(src[13]), .dsp_y1(src[14]), .gpr_rd_idx, .gpr_rd_data,
        .gpr_we, .gpr_wr_idx, .gpr_wr_data, .mem_we, .mem_addr, .mem_data, .addr_error,
        .unknown_op, .done, .pc_next, .other_retire, .int_block);
    scsre_core_model scsre_core_model_inst (.clk, .gpr_rd_idx, .gpr_rd_data, .gpr_we,
        .gpr_wr_idx, .gpr_wr_data);

    always #50 clk = ~clk;

    // hang guard; the run needs about 60 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // offer at the falling edge, return once the answer has settled
    task automatic offer(input logic [15:0] op);
        issue_valid = 1'b1;
        opcode = op;
        pc = pc + 32'h4;
        @(negedge clk);
    endtask

    task automatic idle();
        issue_valid = 1'b0;
        @(negedge clk);
    endtask

    // all register forms back to back, rn walking with the source
    task automatic t_to_gpr();
        for (int i = 0; i < 15; i++) begin
            offer({4'h0, 4'(i), lo_g[i]});
            chk({gpr_we, mem_we, done, gpr_wr_idx}, {3'b101, 4'(i)}, "gpr form");
            chk(gpr_wr_data, src[i], "gpr data");
            chk(pc_next, pc + 32'h2, "pc_next");
        end
        idle();
    endtask

    // every push; control forms must stall for a second cycle
    task automatic t_push();
        logic [31:0] base;
        for (int i = 0; i < 15; i++) begin
            base = 32'h2000_0100 + 32'(i * 16);
            scsre_core_model_inst.gpr[i] = base;
            offer({4'h4, 4'(i), lo_p[i]});
            chk({gpr_we, mem_we, addr_error}, 3'b110, "push strobes");
            chk(gpr_wr_data ^ mem_addr, 32'h0, "addr pair");
            chk(mem_addr, base - 32'h4, "mem_addr");
            chk(mem_data, src[i], "mem_data");
            chk({issue_ready, done}, {2{i > 5}}, "first cycle");
            if (i < 6) begin
                idle();
                chk({issue_ready, done}, 2'b11, "second cycle");
            end
        end
        idle();
    endtask

    // dsp forms are refused without the dsp variant
    task automatic t_dsp_off();
        dsp_en = 1'b0;
        offer(16'h0352);
        chk({unknown_op, gpr_we, done}, 3'b100, "mod off");
        chk(pc_next, pc - 32'h2, "pc_next held");
        offer(16'h4382);
        chk({unknown_op, mem_we, done}, 3'b100, "x0 push off");
        offer(16'h0302);
        chk({unknown_op, done}, 2'b01, "status off");
        dsp_en = 1'b1;
        idle();
    endtask

    // narrow mac high extends bit 9 to both destinations, wide keeps 32 bits
    task automatic t_narrow();
        mac_narrow = 1'b1;
        src[6] = 32'h1234_5a77;
        offer(16'h070a);
        chk(gpr_wr_data, 32'hffff_fe77, "mac_high narrow");
        src[6] = 32'hffff_fd55;
        offer(16'h4802);
        chk(mem_data, 32'h0000_0155, "mac_high push narrow");
        mac_narrow = 1'b0;
        offer(16'h4802);
        chk(mem_data, 32'hffff_fd55, "mac_high push wide");
        idle();
    endtask

    // misaligned push still updates the gpr, write withheld
    task automatic t_misalign();
        scsre_core_model_inst.gpr[5] = 32'h3000_0006;
        offer(16'h4522);
        chk(gpr_wr_data, 32'h3000_0002, "misaligned gpr");
        chk({addr_error, mem_we, done}, 3'b101, "misaligned flags");
        idle();
    endtask

    // block holds until another instruction retires
    task automatic t_int();
        offer(16'h012a);
        repeat (3) idle();
        chk(int_block, 1'b1, "int_block held");
        other_retire = 1'b1;
        @(negedge clk);
        other_retire = 1'b0;
        chk(int_block, 1'b0, "int_block cleared");
        idle();
        // own completion and a retire in one cycle: the set must win
        other_retire = 1'b1;
        offer(16'h022a);
        other_retire = 1'b0;
        chk(int_block, 1'b1, "int_block set wins");
        idle();
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 15; i++) begin
            src[i] = 32'h0101_0000 * 32'(i + 1) + 32'h0000_0a5c;
        end
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk({issue_ready, gpr_we, mem_we, done, int_block}, 5'b10000, "after reset");
        t_to_gpr();
        t_push();
        t_dsp_off();
        t_narrow();
        t_misalign();
        t_int();
        report_and_stop();
    end
endmodule
